// file: src/sfmr_defines.svh
`ifndef SFMR_DEFINES_SVH
`define SFMR_DEFINES_SVH

// Descriptor field positions within the 32-bit send descriptor.
`define SFMR_DESC_W          32
`define SFMR_DESC_CTRL_LSB   0
`define SFMR_DESC_CTRL_MSB   15
`define SFMR_DESC_RLEN_LSB   16
`define SFMR_DESC_RLEN_MSB   19
`define SFMR_DESC_PLEN_LSB   20
`define SFMR_DESC_PLEN_MSB   23
`define SFMR_DESC_UNIT_LSB   24
`define SFMR_DESC_UNIT_MSB   27

// Destination unit codes.
`define SFMR_UNIT_NULL       4'h0
`define SFMR_UNIT_MATH       4'h1
`define SFMR_UNIT_SAMPLER    4'h2
`define SFMR_UNIT_GATEWAY    4'h3
`define SFMR_UNIT_DATAPORT   4'h4
`define SFMR_UNIT_RETSTORE   4'h5
`define SFMR_UNIT_LAUNCHER   4'h6

`define SFMR_NUM_UNITS       7
`define SFMR_PLEN_MIN        4'h1
`define SFMR_PLEN_MAX        4'hf

`endif

// file: src/sfmr_pkg.sv
package sfmr_pkg;
    typedef logic [3:0]  sfmr_unit_t;
    typedef logic [15:0] sfmr_ctrl_t;
    typedef logic [3:0]  sfmr_len_t;
    typedef logic [7:0]  sfmr_greg_t;
endpackage

// file: src/sfmr_arb_if.sv
`timescale 1ns/100ps
interface sfmr_arb_if #(parameter int N = 4);
    logic [N-1:0] req;
    logic [N-1:0] gnt;
    logic         busy;
    modport master (output req, output busy, input gnt);
    modport arbiter (input req, input busy, output gnt);
endinterface

// file: src/sfmr_rr_arb.sv
`timescale 1ns/100ps
module sfmr_rr_arb #(
    parameter int N = 4
) (
    input  wire logic   clk_sys,
    input  wire logic   rst_b,
    sfmr_arb_if.arbiter arb
);
    logic [N-1:0] last_reg;
    logic [N-1:0] gnt_next;

    // Round robin keeps any core from being starved by a lower index.
    always_comb
    begin
        gnt_next = '0;
        for (int k = 1; k <= N; k++)
        begin
            for (int i = 0; i < N; i++)
            begin
                if (gnt_next == '0 && last_reg[(i - k + N) % N] && arb.req[i])
                begin
                    gnt_next[i] = 1'b1;
                end
            end
        end
        if (arb.busy)
        begin
            gnt_next = '0;
        end
    end

    assign arb.gnt = gnt_next;

    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            last_reg <= {{(N-1){1'b0}}, 1'b1};
        end
        else if (gnt_next != '0)
        begin
            last_reg <= gnt_next;
        end
    end
endmodule

// file: src/sfmr_router.sv
`timescale 1ns/100ps
`include "sfmr_defines.svh"

// How it works
// - Each message goes to at most one unit chosen by its 4-bit descriptor code; codes 7 to 15 are absorbed like null.
// - The 16-bit function-control field travels with the message to the unit.
// - The router never decodes the sub-function code.
// - Routing ignores the control field; payload-coded or implied codes pass untouched.
// - Responses return to the sender; the gateway may name another core.
// - A message carries unit code, operation code, writeback register and payload words.
// - Destinations: math, sampler, data port, gateway, return store, launcher, null.
// - Null destination consumes the message and produces no response.
// - Thread-start requests are arbitrated by the separate dispatcher, not this router.
// - Payload length is 1 to 15 registers; descriptor states payload and response lengths.
// - Writebacks are whole registers to the sender's or gateway-named core's file from the named start register.
module sfmr_router
    import sfmr_pkg::*;
#(
    parameter int NC = 4,
    parameter int DW = 256,
    parameter int CW = $clog2(NC)
) (
    input  wire logic                 clk_sys,
    input  wire logic                 rst_b,
    input  wire logic [NC-1:0]        snd_valid,
    input  wire logic [NC*32-1:0]     snd_desc,
    input  wire logic [NC*8-1:0]      snd_greg,
    input  wire logic [NC*DW-1:0]     snd_data,
    input  wire logic [NC-1:0]        snd_last,
    output logic      [NC-1:0]        snd_ready_reg,
    output logic      [NC-1:0]        snd_len_err_reg,
    output logic      [6:0]           fn_valid_reg,
    input  wire logic [6:0]           fn_ready,
    output logic      [15:0]          fn_ctrl_reg,
    output logic      [CW-1:0]        fn_src_reg,
    output logic      [7:0]           fn_greg_reg,
    output logic      [3:0]           fn_rlen_reg,
    output logic      [DW-1:0]        fn_data_reg,
    output logic                      fn_last_reg,
    input  wire logic                 rsp_valid,
    input  wire logic [CW-1:0]        rsp_src,
    input  wire logic                 rsp_gw_redirect,
    input  wire logic [CW-1:0]        rsp_gw_core,
    input  wire logic [7:0]           rsp_greg,
    input  wire logic [DW-1:0]        rsp_data,
    output logic      [NC-1:0]        wb_valid_reg,
    output logic      [7:0]           wb_greg_reg,
    output logic      [DW-1:0]        wb_data_reg
);
    typedef enum logic [1:0] {S_IDLE, S_MOVE} sfmr_state_t;

    sfmr_state_t    state_reg;
    logic [CW-1:0]  cur_reg;
    sfmr_unit_t     unit_reg;
    sfmr_len_t      left_reg;
    logic [NC-1:0]  gnt;
    logic [CW-1:0]  gidx;
    logic [31:0]    gdesc;
    sfmr_unit_t     gunit;
    sfmr_len_t      gplen;
    logic           dst_ok;
    logic           beat;
    logic           acc;

    sfmr_arb_if #(.N(NC)) arb ();
    assign arb.req  = snd_valid;
    assign arb.busy = (state_reg != S_IDLE);

    sfmr_rr_arb #(.N(NC)) u_arb (
        .clk_sys (clk_sys),
        .rst_b   (rst_b),
        .arb     (arb)
    );
    assign gnt = arb.gnt;

    always_comb
    begin
        gidx = '0;
        for (int i = 0; i < NC; i++)
        begin
            if (gnt[i])
            begin
                gidx = CW'(i);
            end
        end
    end

    assign gdesc = snd_desc[gidx*32 +: 32];
    assign gunit = gdesc[`SFMR_DESC_UNIT_MSB:`SFMR_DESC_UNIT_LSB];
    assign gplen = gdesc[`SFMR_DESC_PLEN_MSB:`SFMR_DESC_PLEN_LSB];

    // The unit handshake is registered, so a beat moves when the unit is ready
    // and no valid is already pending. Null accepts every beat itself.
    assign dst_ok = (unit_reg == `SFMR_UNIT_NULL) ? 1'b1
                  : (unit_reg < 4'(`SFMR_NUM_UNITS)) ? fn_ready[unit_reg[2:0]] : 1'b1;
    assign beat   = (state_reg == S_MOVE) && snd_valid[cur_reg] && dst_ok
                    && (fn_valid_reg == '0) && !snd_ready_reg[cur_reg];
    assign acc    = |gnt && (gplen >= `SFMR_PLEN_MIN) && (gplen <= `SFMR_PLEN_MAX);

    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            state_reg <= S_IDLE;
            cur_reg   <= '0;
            unit_reg  <= `SFMR_UNIT_NULL;
            left_reg  <= '0;
        end
        else
        begin
            unique case (state_reg)
                S_IDLE:
                begin
                    if (acc)
                    begin
                        state_reg <= S_MOVE;
                        cur_reg   <= gidx;
                        unit_reg  <= gunit;
                        left_reg  <= gplen;
                    end
                end
                S_MOVE:
                begin
                    if (beat)
                    begin
                        left_reg <= left_reg - 4'h1;
                        if (left_reg == 4'h1)
                        begin
                            state_reg <= S_IDLE;
                        end
                    end
                end
            endcase
        end
    end

    // A zero-length descriptor is refused with a pulse rather than stalling the bus.
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            snd_len_err_reg <= '0;
        end
        else
        begin
            snd_len_err_reg <= (|gnt && !acc) ? gnt : '0;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            snd_ready_reg <= '0;
        end
        else
        begin
            snd_ready_reg <= '0;
            if (beat)
            begin
                snd_ready_reg[cur_reg] <= 1'b1;
            end
        end
    end

    // Control field is copied verbatim; no branch ever looks at it.
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            fn_valid_reg <= '0;
            fn_ctrl_reg  <= '0;
            fn_src_reg   <= '0;
            fn_greg_reg  <= '0;
            fn_rlen_reg  <= '0;
            fn_data_reg  <= '0;
            fn_last_reg  <= 1'b0;
        end
        else
        begin
            fn_valid_reg <= '0;
            if (beat)
            begin
                if (unit_reg != `SFMR_UNIT_NULL && unit_reg < 4'(`SFMR_NUM_UNITS))
                begin
                    fn_valid_reg[unit_reg[2:0]] <= 1'b1;
                end
                fn_ctrl_reg <= snd_desc[cur_reg*32 +: 16];
                fn_rlen_reg <= snd_desc[cur_reg*32 + `SFMR_DESC_RLEN_LSB +: 4];
                fn_src_reg  <= cur_reg;
                fn_greg_reg <= snd_greg[cur_reg*8 +: 8];
                fn_data_reg <= snd_data[cur_reg*DW +: DW];
                fn_last_reg <= (left_reg == 4'h1);
            end
        end
    end

    // Each response beat is one whole register for the target core.
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            wb_valid_reg <= '0;
            wb_greg_reg  <= '0;
            wb_data_reg  <= '0;
        end
        else
        begin
            wb_valid_reg <= '0;
            if (rsp_valid)
            begin
                wb_valid_reg[rsp_gw_redirect ? rsp_gw_core : rsp_src] <= 1'b1;
                wb_greg_reg <= rsp_greg;
                wb_data_reg <= rsp_data;
            end
        end
    end

    sequence s_beat;
        beat && unit_reg != `SFMR_UNIT_NULL && unit_reg < 4'(`SFMR_NUM_UNITS);
    endsequence

    AST_ONE_HOT_FN: assert property (@(posedge clk_sys) disable iff (!rst_b)
        $onehot0(fn_valid_reg)) else $error("more than one unit valid");
    AST_CTRL_PASS: assert property (@(posedge clk_sys) disable iff (!rst_b)
        beat |=> fn_ctrl_reg == $past(snd_desc[cur_reg*32 +: 16]))
        else $error("control field not passed");
    AST_ROUTE: assert property (@(posedge clk_sys) disable iff (!rst_b)
        s_beat |=> fn_valid_reg[$past(unit_reg[2:0])]) else $error("wrong unit");
    AST_WB_SRC: assert property (@(posedge clk_sys) disable iff (!rst_b)
        rsp_valid && !rsp_gw_redirect |=> wb_valid_reg[$past(rsp_src)])
        else $error("response to wrong core");
    AST_WB_GW: assert property (@(posedge clk_sys) disable iff (!rst_b)
        rsp_valid && rsp_gw_redirect |=> wb_valid_reg[$past(rsp_gw_core)])
        else $error("gateway redirect failed");
    AST_NULL: assert property (@(posedge clk_sys) disable iff (!rst_b)
        beat && unit_reg == `SFMR_UNIT_NULL |=> fn_valid_reg == '0)
        else $error("null unit produced output");
    AST_LEN: assert property (@(posedge clk_sys) disable iff (!rst_b)
        |gnt && gplen == 4'h0 |=> snd_len_err_reg == $past(gnt) && state_reg == S_IDLE)
        else $error("empty payload not refused");
    AST_ONE_MSG: assert property (@(posedge clk_sys) disable iff (!rst_b)
        state_reg == S_MOVE |-> gnt == '0 ##1 (state_reg == S_IDLE || $stable(cur_reg)))
        else $error("grant during message");
    AST_WB_GREG: assert property (@(posedge clk_sys) disable iff (!rst_b)
        rsp_valid |=> wb_greg_reg == $past(rsp_greg)) else $error("writeback register");
    AST_LAST: assert property (@(posedge clk_sys) disable iff (!rst_b)
        beat |=> fn_last_reg == (state_reg == S_IDLE)) else $error("last beat flag wrong");
endmodule

// file: tb/sfmr_fn_model.sv
`timescale 1ns/100ps
module sfmr_fn_model (
    input  wire logic        clk_sys,
    input  wire logic        rst_b,
    input  wire logic        stall,
    input  wire logic [6:0]  fn_valid_reg,
    input  wire logic        fn_last_reg,
    input  wire logic [15:0] fn_ctrl_reg,
    output logic      [6:0]  fn_ready,
    output int               beats_reg,
    output int               lasts_reg,
    output logic      [6:0]  unit_reg,
    output logic      [15:0] ctrl_reg
);
    // A stalled unit drops readiness, so the router must hold the pending beat.
    assign fn_ready = stall ? 7'h00 : 7'h7f;
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            beats_reg <= 0;
            lasts_reg <= 0;
            unit_reg  <= 7'h00;
            ctrl_reg  <= 16'h0000;
        end
        else if (fn_valid_reg != 7'h00)
        begin
            beats_reg <= beats_reg + $countones(fn_valid_reg);
            lasts_reg <= lasts_reg + int'(fn_last_reg);
            unit_reg  <= fn_valid_reg;
            ctrl_reg  <= fn_ctrl_reg;
        end
    end
endmodule

// file: tb/test_shared_function_message_router.sv
`timescale 1ns/100ps
module test_shared_function_message_router;
    import sfmr_pkg::*;
    localparam int DW = 16;
    logic          clk_sys, rst_b, stall, rsp_valid, rsp_gw_redirect, fn_last_reg;
    logic [3:0]    snd_valid, snd_ready_reg, snd_len_err_reg, wb_valid_reg, fn_rlen_reg;
    logic [127:0]  snd_desc;
    logic [31:0]   snd_greg;
    logic [63:0]   snd_data;
    logic [6:0]    fn_valid_reg, fn_ready;
    logic [15:0]   fn_ctrl_reg;
    logic [1:0]    fn_src_reg, rsp_src, rsp_gw_core;
    logic [7:0]    fn_greg_reg, rsp_greg, wb_greg_reg;
    logic [DW-1:0] fn_data_reg, rsp_data, wb_data_reg;
    int            fail_count, tests_run;

    sfmr_router #(.NC(4), .DW(DW)) i_dut (
        .clk_sys(clk_sys), .rst_b(rst_b), .snd_valid(snd_valid), .snd_desc(snd_desc),
        .snd_greg(snd_greg), .snd_data(snd_data), .snd_last(4'h0),
        .snd_ready_reg(snd_ready_reg), .snd_len_err_reg(snd_len_err_reg),
        .fn_valid_reg(fn_valid_reg), .fn_ready(fn_ready), .fn_ctrl_reg(fn_ctrl_reg),
        .fn_src_reg(fn_src_reg), .fn_greg_reg(fn_greg_reg), .fn_rlen_reg(fn_rlen_reg),
        .fn_data_reg(fn_data_reg), .fn_last_reg(fn_last_reg), .rsp_valid(rsp_valid),
        .rsp_src(rsp_src), .rsp_gw_redirect(rsp_gw_redirect), .rsp_gw_core(rsp_gw_core),
        .rsp_greg(rsp_greg), .rsp_data(rsp_data), .wb_valid_reg(wb_valid_reg),
        .wb_greg_reg(wb_greg_reg), .wb_data_reg(wb_data_reg));

    sfmr_fn_model i_fn (
        .clk_sys(clk_sys), .rst_b(rst_b), .stall(stall), .fn_valid_reg(fn_valid_reg),
        .fn_last_reg(fn_last_reg), .fn_ctrl_reg(fn_ctrl_reg), .fn_ready(fn_ready),
        .beats_reg(), .lasts_reg(), .unit_reg(), .ctrl_reg());

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("unexpected at %0t: got %h want %h", $time, seen, exp);
        end
    endtask

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // Holds each beat until the router acknowledges it, then moves to the next register.
    task automatic send(input int c, input logic [3:0] u, input logic [3:0] n,
                        input logic [15:0] ctl);
        int k;
        @(negedge clk_sys);
        snd_desc[c*32 +: 32] = {4'h0, u, n, 4'h1, ctl};
        snd_greg[c*8 +: 8] = 8'h20 + 8'(c);
        snd_valid[c] = 1'b1;
        for (int b = 0; b < int'(n); b++)
        begin
            snd_data[c*DW +: DW] = 16'h0a00 + 16'(b);
            k = 0;
            do
            begin
                @(negedge clk_sys);
                k++;
            end
            while (snd_ready_reg[c] !== 1'b1 && k < 200);
            check(32'(k < 200), 32'h1);
        end
        snd_valid[c] = 1'b0;
    endtask

    task automatic route_all();
        int b0;
        for (int u = 0; u < 7; u++)
        begin
            b0 = i_fn.beats_reg;
            send(u % 4, 4'(u), 4'h2, 16'hc000 + 16'(u));
            repeat (3) @(negedge clk_sys);
            check(32'(i_fn.beats_reg - b0), (u == 0) ? 32'h0 : 32'h2);
            check(32'(fn_src_reg), 32'(u % 4));
            check(32'(fn_greg_reg), 32'h20 + 32'(u % 4));
            check(32'(fn_rlen_reg), 32'h1);
            check(32'(fn_data_reg), 32'h0a01);
            check(32'(fn_last_reg), 32'h1);
            if (u != 0)
            begin
                check(32'(i_fn.unit_reg), 32'(7'h01 << u));
                check(32'(i_fn.ctrl_reg), 32'hc000 + 32'(u));
            end
        end
        $display("routing test done");
    endtask

    // A refused sender withdraws its request; left up, the router refuses it again each cycle.
    task automatic long_and_empty();
        int b0;
        int e0;
        b0 = i_fn.lasts_reg;
        send(1, 4'h1, 4'hf, 16'h0000);
        repeat (3) @(negedge clk_sys);
        check(32'(i_fn.lasts_reg - b0), 32'h1);
        @(negedge clk_sys);
        snd_desc[95:64] = {4'h0, 4'h2, 4'h0, 4'h1, 16'h0000};
        snd_valid[2] = 1'b1;
        b0 = 0;
        e0 = i_fn.beats_reg;
        repeat (6)
        begin
            @(negedge clk_sys);
            if (snd_len_err_reg[2] === 1'b1)
            begin
                b0++;
                snd_valid[2] = 1'b0;
            end
        end
        snd_valid[2] = 1'b0;
        check(32'(b0), 32'h1);
        check(32'(i_fn.beats_reg - e0), 32'h0);
        e0 = i_fn.beats_reg;
        send(0, 4'h9, 4'h1, 16'h0000);
        repeat (3) @(negedge clk_sys);
        check(32'(i_fn.beats_reg - e0), 32'h0);
        $display("length test done");
    endtask

    task automatic contend();
        int b0;
        b0 = i_fn.beats_reg;
        fork
            send(0, 4'h2, 4'h3, 16'h1111);
            send(3, 4'h2, 4'h4, 16'h2222);
            begin
                stall = 1'b1;
                repeat (10) @(negedge clk_sys);
                stall = 1'b0;
            end
        join
        repeat (3) @(negedge clk_sys);
        check(32'(i_fn.beats_reg - b0), 32'h7);
        $display("contention test done");
    endtask

    task automatic respond(input logic [1:0] src, input logic redir, input logic [3:0] exp);
        logic [3:0] got;
        @(negedge clk_sys);
        {rsp_valid, rsp_src, rsp_gw_redirect, rsp_gw_core} = {1'b1, src, redir, 2'h1};
        rsp_greg = 8'h30;
        rsp_data = 16'hbeef;
        got = 4'h0;
        @(negedge clk_sys);
        rsp_valid = 1'b0;
        repeat (3)
        begin
            if (wb_valid_reg != 4'h0 && got == 4'h0)
                got = wb_valid_reg;
            @(negedge clk_sys);
        end
        check(32'(got), 32'(exp));
        check({wb_greg_reg, wb_data_reg}, 32'h0030beef);
    endtask

    initial
    begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end

    initial
    begin
        repeat (20000) @(posedge clk_sys);
        fail_count++;
        print_verdict();
    end

    initial
    begin
        {rst_b, stall, rsp_valid, rsp_gw_redirect, snd_valid} = '0;
        {snd_desc, snd_greg, snd_data, rsp_src, rsp_gw_core, rsp_greg, rsp_data} = '0;
        repeat (20) @(negedge clk_sys);
        rst_b = 1'b1;
        route_all();
        long_and_empty();
        contend();
        respond(2'h2, 1'b0, 4'h4);
        respond(2'h2, 1'b1, 4'h2);
        $display("response test done");
        print_verdict();
    end
endmodule
